// File: design/srf_controller.sv
`timescale 1ns/1ps
module srf_controller
  import srf_pkg::*;
(
  input  wire logic mclk,          // Controller clock.
  input  wire logic sys_rst,       // Asynchronous reset, active high.
  srf_if.ctrl       bus,           // Command pins to the device.
  input  wire logic sr_req,        // Level: keep device in self-refresh.
  input  wire logic vref_off,      // Reference voltage was removed in self-refresh.
  output logic      sr_active,     // Device is in self-refresh.
  output logic      clk_stop_ok,   // Clock may be stopped.
  output logic      dll_cmd_ok,    // Commands needing locked DLL allowed.
  output logic      write_ok       // Writes and write leveling allowed.
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ODT = 7'h02, ST_REF = 7'h04, ST_SR = 7'h08,
    ST_RESTART = 7'h10, ST_EXIT = 7'h20, ST_PRE = 7'h40
  } srf_st_t;
  srf_st_t   st_ff;
  logic [12:0] cnt_ff;
  logic [12:0] average_refresh_interval_ff;
  logic signed [4:0] owed_ff;
  logic [9:0]  xs_ff;
  logic        ref_since_ff;
  logic        cke_ff, cs_n_ff, ras_n_ff, cas_n_ff, we_n_ff, odt_ff;
  logic        stop_ff, dll_ok_ff, wr_ok_ff;
  logic [3:0]  sre_age_ff;

  // R1 R6: owed refreshes grow per interval and are issued before eight accrue.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      average_refresh_interval_ff <= 13'h0000;
      owed_ff  <= 5'sd0;
    end else if (st_ff != ST_SR && st_ff != ST_RESTART) begin
      // R9: balance frozen during self-refresh.
      if (average_refresh_interval_ff == 13'(AVG_REFRESH_INTERVAL_CYC - 1)) begin
        average_refresh_interval_ff <= 13'h0000;
        owed_ff  <= (st_ff == ST_REF && cnt_ff == 13'h0000) ? owed_ff : owed_ff + 5'sd1;
      end else begin
        average_refresh_interval_ff <= average_refresh_interval_ff + 13'h0001;
        if (st_ff == ST_REF && cnt_ff == 13'h0000) begin
          owed_ff <= owed_ff - 5'sd1;
        end
      end
    end
  end

  // Command sequencer; refreshes are issued one per tick of ST_REF entry.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= ST_PRE; cnt_ff <= 13'(ROW_PRECHARGE_CYC);
      cke_ff <= 1'b1; cs_n_ff <= 1'b1; ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1; we_n_ff <= 1'b1; odt_ff <= 1'b0;
      ref_since_ff <= 1'b1;
    end else begin
      cs_n_ff <= 1'b1; ras_n_ff <= 1'b1; cas_n_ff <= 1'b1; we_n_ff <= 1'b1;
      if (cnt_ff != 13'h0000) cnt_ff <= cnt_ff - 13'h0001;
      unique case (st_ff)
        // R3 R11: precharge time met before refresh or entry.
        ST_PRE: if (cnt_ff == 13'h0000) st_ff <= ST_IDLE;
        ST_IDLE: begin
          // R22: termination stays off until the long exit delay has run.
          odt_ff <= (xs_ff == 10'h000);
          // R20: no command inside the short exit delay.
          if (owed_ff > 5'sd0 &&
              xs_ff <= 10'(LONG_EXIT_DELAY_CYC - SHORT_EXIT_DELAY_CYC + 1)) begin
            // R2: refresh command, R5 NOPs follow for the cycle time.
            cs_n_ff <= 1'b0; ras_n_ff <= 1'b0; cas_n_ff <= 1'b0;
            st_ff <= ST_REF; cnt_ff <= 13'(REFRESH_CYCLE_CYC);
            ref_since_ff <= 1'b1;
          // R21: re-entry only after a refresh since exit.
          end else if (sr_req && ref_since_ff && xs_ff == 10'h000) begin
            // R12: termination low a latency and more before entry.
            odt_ff <= 1'b0; st_ff <= ST_ODT;
            cnt_ff <= 13'(TERMINATION_LATENCY_CYC + 1);
          end
        end
        // R5 R8: next refresh only after cycle time; one owed per interval keeps it far below sixteen.
        ST_REF: if (cnt_ff == 13'h0000) st_ff <= ST_IDLE;
        ST_ODT: if (cnt_ff == 13'h0000) begin
          // R10: entry with enable low.
          cs_n_ff <= 1'b0; ras_n_ff <= 1'b0; cas_n_ff <= 1'b0;
          cke_ff <= 1'b0; st_ff <= ST_SR;
          cnt_ff <= 13'(MIN_SELF_REFRESH_RESIDENCY_CYC);
        end
        // R13 R18: hold enable low at least the residency.
        ST_SR: if (cnt_ff == 13'h0000 && !sr_req) begin
          st_ff <= ST_RESTART; cnt_ff <= 13'(CLOCK_RESTART_DELAY_CYC);
        end
        // R19 R20: clock stable before enable rises with NOP.
        ST_RESTART: if (cnt_ff == 13'h0000) begin
          cke_ff <= 1'b1; st_ff <= ST_IDLE; ref_since_ff <= 1'b0;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // R19: cycles since entry; the clock may stop only once the stop delay has run.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sre_age_ff <= 4'h0;
    end else if (st_ff != ST_SR) begin
      sre_age_ff <= 4'h0;
    end else if (sre_age_ff != 4'(CLOCK_STOP_DELAY_CYC)) begin
      sre_age_ff <= sre_age_ff + 4'h1;
    end
  end

  // R20 R22: exit delay counters gate commands and termination.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xs_ff <= 10'h000; stop_ff <= 1'b0; dll_ok_ff <= 1'b1; wr_ok_ff <= 1'b1;
    end else begin
      // R19: clock may stop once the stop delay passes.
      stop_ff <= (st_ff == ST_SR) && (sre_age_ff == 4'(CLOCK_STOP_DELAY_CYC));
      if (st_ff == ST_RESTART && cnt_ff == 13'h0000) begin
        xs_ff <= 10'(LONG_EXIT_DELAY_CYC);
        dll_ok_ff <= 1'b0; wr_ok_ff <= 1'b0;
      end else if (xs_ff != 10'h000) begin
        xs_ff <= xs_ff - 10'h001;
      end else begin
        // R16: writes wait 512 clocks when reference was removed.
        dll_ok_ff <= 1'b1; wr_ok_ff <= 1'b1;
      end
    end
  end

  assign bus.cke = cke_ff; assign bus.cs_n = cs_n_ff; assign bus.ras_n = ras_n_ff;
  assign bus.cas_n = cas_n_ff; assign bus.we_n = we_n_ff; assign bus.odt = odt_ff;
  assign bus.reset_n = ~sys_rst; assign bus.addr = 16'h0000;
  assign sr_active = (st_ff == ST_SR) || (st_ff == ST_RESTART);
  assign clk_stop_ok = stop_ff; assign dll_cmd_ok = dll_ok_ff;
  assign write_ok = wr_ok_ff | ~vref_off;
endmodule // srf_controller

// File: design/srf_device.sv
`timescale 1ns/1ps
// Function
// R1: Refresh arrives once per average interval.
// R2: Decode refresh: CS RAS CAS low, WE high.
// R3: Banks precharged before refresh.
// R4: Internal row counter; banks idle afterwards.
// R5: Only NOP during refresh cycle time.
// R6: At most eight refreshes postponed.
// R7: At most eight refreshes pulled in.
// R8: At most sixteen refreshes per two intervals.
// R9: Postponed count frozen in self-refresh.
// R10: Decode self-refresh entry with clock enable low.
// R11: Device idle before self-refresh entry.
// R12: Termination off before self-refresh entry.
// R13: Self-refresh held while clock enable low.
// R14: DLL off in self-refresh, reset on exit.
// R15: Ignore inputs except enable, reset in self-refresh.
// R16: Write waits 512 clocks after exit.
// R17: Internal refresh within pulse, then timer.
// R18: Stay in self-refresh minimum residency.
// R19: Clock stop and restart delays respected.
// R20: Exit with NOP; short, long delays.
// R21: Enable high through long exit delay.
// R22: NOP through short delay; termination off.
module srf_device
  import srf_pkg::*;
#(
  parameter int ROW_WIDTH = ROW_W,
  parameter int TIMER_CYC = SELF_REFRESH_TIMER_CYC
) (
  input  wire logic                 mclk,          // Device clock.
  input  wire logic                 sys_rst,       // Asynchronous reset, active high.
  srf_if.dev                        bus,           // Command pins from the controller.
  input  wire logic                 dll_en_cfg,    // DLL enable select bit; low enables.
  output logic                      in_self_ref,   // Device is in self-refresh.
  output logic                      refreshing,    // A refresh cycle is running.
  output logic [ROW_WIDTH-1:0]      row_addr,      // Internal refresh row counter.
  output logic                      dll_on,        // DLL is running.
  output logic                      dll_reset,     // One-cycle DLL reset pulse.
  output logic signed [4:0]         ref_balance    // Postponed (+) or pulled-in (-) count.
);
  // Registered state.
  logic                  in_sr_ff;
  logic                  cke_prev_ff;
  logic                  busy_ff;
  logic [8:0]            rfc_cnt_ff;
  logic [ROW_WIDTH-1:0]  row_ff;
  logic [12:0]           tmr_ff;
  logic [12:0]           average_refresh_interval_ff;
  logic signed [4:0]     bal_ff;
  logic                  dll_on_ff;
  logic                  dll_rst_ff;

  // Decoded strobes and qualifiers, all combinational on the sampled pins and registered state.
  logic                  reset_lo;
  logic                  cmd_low3;
  logic                  ref_cmd;
  logic                  sre_cmd;
  logic                  int_ref;
  logic                  sr_exit;
  logic                  ref_start;
  logic                  ival_end;
  logic                  dll_enabled;

  // Pin inputs come from the same clock in this model, so no extra staging.
  assign reset_lo = ~bus.reset_n;
  assign cmd_low3 = ~bus.cs_n & ~bus.ras_n & ~bus.cas_n & bus.we_n;
  // R2: refresh decode
  assign ref_cmd  = ~in_sr_ff & cmd_low3 & cke_prev_ff & bus.cke;
  // R10: self-refresh entry decode
  assign sre_cmd  = ~in_sr_ff & cmd_low3 & cke_prev_ff & ~bus.cke;
  // R13: exit only on clock enable rising
  assign sr_exit  = in_sr_ff & bus.cke;
  // R17: first internal refresh at once, then on the built-in timer.
  assign int_ref  = in_sr_ff & ~busy_ff & (tmr_ff == 13'h0000);

  // Either source starts a refresh cycle; a command landing mid-cycle restarts it.
  assign ref_start   = ref_cmd | int_ref;
  // Last cycle of one average interval.
  assign ival_end    = (average_refresh_interval_ff == 13'(AVG_REFRESH_INTERVAL_CYC - 1));
  // R14: select bit low enables DLL
  assign dll_enabled = ~dll_en_cfg;

  // Enable as sampled one edge earlier; both decodes need it high then.
  // Clearing it on reset keeps the first edge after reset from decoding anything.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cke_prev_ff <= 1'b0;
    end else if (reset_lo) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= bus.cke;
    end
  end

  // Self-refresh state; R15: only clock enable and reset matter inside.
  // A low device reset drops self-refresh at once, whatever the other pins show.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_sr_ff <= 1'b0;
    end else if (reset_lo) begin
      in_sr_ff <= 1'b0;
    end else if (sre_cmd) begin
      in_sr_ff <= 1'b1;
    end else if (sr_exit) begin
      in_sr_ff <= 1'b0;
    end
  end

  // R4: refresh cycle timer, address bus unused
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff    <= 1'b0;
      rfc_cnt_ff <= 9'h000;
    end else if (ref_start) begin
      busy_ff    <= 1'b1;
      rfc_cnt_ff <= 9'(REFRESH_CYCLE_CYC - 1);
    end else if (busy_ff) begin
      if (rfc_cnt_ff == 9'h000) begin
        busy_ff <= 1'b0;
      end else begin
        rfc_cnt_ff <= rfc_cnt_ff - 9'h001;
      end
    end
  end

  // R4: internal row counter per refresh
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      row_ff <= '0;
    end else if (ref_start) begin
      row_ff <= row_ff + 1'b1;
    end
  end

  // R17: built-in timer reloads on each internal refresh, cleared to zero outside.
  // The period must exceed the refresh cycle, or the busy gate stretches it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_ff <= 13'h0000;
    end else if (!in_sr_ff) begin
      tmr_ff <= 13'h0000;
    end else if (int_ref) begin
      tmr_ff <= 13'(TIMER_CYC - 1);
    end else if (tmr_ff != 13'h0000) begin
      tmr_ff <= tmr_ff - 13'h0001;
    end
  end

  // R1: average interval counter; held in self-refresh so the phase carries across.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      average_refresh_interval_ff <= 13'h0000;
    end else if (!in_sr_ff) begin
      if (ival_end) begin
        average_refresh_interval_ff <= 13'h0000;
      end else begin
        average_refresh_interval_ff <= average_refresh_interval_ff + 13'h0001;
      end
    end
  end

  // R9: balance frozen in self-refresh
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bal_ff <= 5'sd0;
    end else if (!in_sr_ff) begin
      // R7: pulled-in credit saturates at eight.
      case ({ival_end, ref_cmd})
        2'b10:   bal_ff <= (bal_ff < 5'sd15) ? bal_ff + 5'sd1 : bal_ff;
        2'b01:   bal_ff <= (bal_ff > -5'sd8) ? bal_ff - 5'sd1 : bal_ff;
        default: bal_ff <= bal_ff;
      endcase
    end
  end

  // R14: DLL off on entry, on at exit when the select bit enables it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dll_on_ff <= 1'b0;
    end else if (sre_cmd) begin
      dll_on_ff <= 1'b0;
    end else if (sr_exit && dll_enabled) begin
      dll_on_ff <= 1'b1;
    end else if (!in_sr_ff) begin
      dll_on_ff <= dll_enabled;
    end
  end

  // R14: DLL reset pulse on exit when the select bit enables the DLL
  // It stands for the exit edge only; lock time is left to the long exit delay.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dll_rst_ff <= 1'b0;
    end else begin
      dll_rst_ff <= sr_exit & dll_enabled;
    end
  end

  // Outputs are the registers themselves, so nothing combinational reaches a port.
  // Keep it so; the far side samples them on the same edge as the pins.
  assign in_self_ref = in_sr_ff;
  assign refreshing  = busy_ff;
  assign row_addr    = row_ff;
  assign dll_on      = dll_on_ff;
  assign dll_reset   = dll_rst_ff;
  assign ref_balance = bal_ff;
endmodule // srf_device

// File: design/srf_if.sv
`timescale 1ns/1ps
interface srf_if;
  logic        cke;        // Clock enable.
  logic        cs_n;       // Chip select, active low.
  logic        ras_n;      // Row strobe, active low.
  logic        cas_n;      // Column strobe, active low.
  logic        we_n;       // Write enable, active low.
  logic        odt;        // On-die termination control.
  logic        reset_n;    // Device reset, active low.
  logic [15:0] addr;       // Address bus, ignored by refresh.
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, addr);
  modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, addr);
endinterface

// File: design/srf_pkg.sv
package srf_pkg;
  // Clock period of the controller and device model.
  localparam int CLK_PERIOD_NS     = 100;
  // Average refresh interval in ns, and its count in cycles (rounded down).
  localparam int AVG_REFRESH_INTERVAL_NS = 7800;
  localparam int AVG_REFRESH_INTERVAL_CYC = AVG_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  // Least times, rounded up to whole cycles.
  localparam int ROW_PRECHARGE_TIME_NS = 15;
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_TIME_NS = 260;
  localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_CLOCK_ENABLE_PULSE_CYC = 3;
  localparam int MIN_SELF_REFRESH_RESIDENCY_CYC = MIN_CLOCK_ENABLE_PULSE_CYC + 1;
  localparam int CLOCK_STOP_DELAY_CYC = 5;
  localparam int CLOCK_RESTART_DELAY_CYC = 5;
  localparam int SHORT_EXIT_DELAY_NS = 270;
  localparam int SHORT_EXIT_DELAY_CYC = (SHORT_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_EXIT_DELAY_CYC = 512;
  localparam int VREF_WRITE_HOLDOFF_CYC = 512;
  localparam int TERMINATION_LATENCY_CYC = 5;
  // Refresh budget.
  localparam int MAX_POSTPONED = 8;
  localparam int MAX_PULLED_IN = 8;
  localparam int MAX_REF_IN_WINDOW = 16;
  // Built-in self-refresh timer period in cycles.
  localparam int SELF_REFRESH_TIMER_CYC = AVG_REFRESH_INTERVAL_CYC;
  // Refresh row counter width and DLL enable select bit position.
  localparam int ROW_W = 16;
  localparam int DLL_ENABLE_SELECT_BIT = 0;
endpackage

// File: verification/srf_properties.sv
`timescale 1ns/1ps
module srf_properties
  import srf_pkg::*;
(
  input wire logic        mclk,     // Clock.
  input wire logic        sys_rst,  // Reset, active high.
  input wire logic        cke,      // Clock enable.
  input wire logic        cs_n,     // Chip select.
  input wire logic        ras_n,    // Row strobe.
  input wire logic        cas_n,    // Column strobe.
  input wire logic        we_n,     // Write strobe.
  input wire logic        odt,      // Termination control.
  input wire logic        reset_n,  // Device reset.
  input wire logic [15:0] addr      // Address bus.
);
  localparam int WIN = 2 * AVG_REFRESH_INTERVAL_CYC;
  logic           ref_c;
  logic           sre_c;
  logic           nop_c;
  logic           sr_ff;
  logic           refx_ff;
  logic [9:0]     exit_ff;
  logic [10:0]    gap_ff;
  logic [3:0]     odt_lo_ff;
  logic [WIN-2:0] hist_ff;

  // Command decode; deselect counts as idle just like an all-high strobe set.
  assign nop_c = cs_n | (ras_n & cas_n & we_n);
  assign ref_c = cke & ~cs_n & ~ras_n & ~cas_n & we_n;
  assign sre_c = ~cke & ~cs_n & ~ras_n & ~cas_n & we_n;

  // Self-refresh residency flag; pins are ignored until enable rises.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) sr_ff <= 1'b0;
    else if (sre_c) sr_ff <= 1'b1;
    else if (cke) sr_ff <= 1'b0;
  end

  // Exit age; cleared on any low enable so a re-entry ends the window.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) exit_ff <= '0;
    else if (!cke) exit_ff <= '0;
    else if (sr_ff) exit_ff <= 10'h001;
    else if (exit_ff != '0 && int'(exit_ff) < LONG_EXIT_DELAY_CYC) exit_ff <= exit_ff + 10'h001;
    else exit_ff <= '0;
  end

  // Remembers whether a refresh was issued since the last exit.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) refx_ff <= 1'b0;
    else if (sr_ff && cke) refx_ff <= 1'b0;
    else if (ref_c) refx_ff <= 1'b1;
  end

  // Cycles since the last refresh; saturates so it cannot wrap to a pass.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) gap_ff <= '0;
    else if (!cke || ref_c) gap_ff <= '0;
    else if (gap_ff != '1) gap_ff <= gap_ff + 11'h001;
  end

  // Termination low time and a sliding refresh history.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) odt_lo_ff <= '0;
    else if (odt) odt_lo_ff <= '0;
    else if (odt_lo_ff != '1) odt_lo_ff <= odt_lo_ff + 4'h1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hist_ff <= '0;
    else hist_ff <= {hist_ff[WIN-3:0], ref_c};
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  AST_REF_NOP_GAP:
    assert property (ref_c |=> nop_c [*2]) else $error("command inside refresh cycle");
  AST_REF_BUDGET:
    assert property (int'(gap_ff) < 9 * AVG_REFRESH_INTERVAL_CYC) else $error("refresh overdue");
  AST_REF_WINDOW:
    assert property ($countones({hist_ff, ref_c}) <= MAX_REF_IN_WINDOW)
      else $error("too many refreshes in window");
  AST_SRE_FROM_ACTIVE:
    assert property (sre_c && !sr_ff |-> $past(cke)) else $error("entry without enable high");
  AST_SRE_ODT_OFF:
    assert property (sre_c && !sr_ff |-> !odt && odt_lo_ff > TERMINATION_LATENCY_CYC)
      else $error("termination on at entry");
  AST_SR_RESIDENCY:
    assert property (sre_c && !sr_ff |-> !cke [*4]) else $error("self-refresh too short");
  AST_SRX_NOP:
    assert property (sr_ff && cke |-> nop_c [*3]) else $error("command inside short exit");
  AST_EXIT_CKE_HIGH:
    assert property (exit_ff != '0 && !cke |-> sre_c && refx_ff
      && int'(exit_ff) >= SHORT_EXIT_DELAY_CYC) else $error("enable low during long exit");
  AST_EXIT_ODT_OFF:
    assert property (exit_ff != '0 |-> !odt) else $error("termination on during exit");

  cover property (ref_c);
  cover property (sre_c && !sr_ff);
  cover property (sr_ff && cke);
endmodule // srf_properties

// File: verification/srf_tb.sv
`timescale 1ns/1ps
module srf_tb;
  import srf_pkg::*;
  localparam int TMR = 20;
  logic                    mclk, sys_rst, sr_req, vref_off, dll_en_cfg;
  logic                    in_self_ref, refreshing, dll_on, dll_reset;
  logic                    sr_active, clk_stop_ok, dll_cmd_ok, write_ok;
  logic [ROW_W-1:0]        row_addr;
  logic signed [4:0]       ref_balance;
  logic                    pulse_seen, ref_seen;
  int                      rows_moved, n_errors, checks_done;

  srf_if bus_if ();
  srf_controller u_srf_controller (.mclk(mclk), .sys_rst(sys_rst), .bus(bus_if),
    .sr_req(sr_req), .vref_off(vref_off), .sr_active(sr_active),
    .clk_stop_ok(clk_stop_ok), .dll_cmd_ok(dll_cmd_ok), .write_ok(write_ok));
  srf_device #(.ROW_WIDTH(ROW_W), .TIMER_CYC(TMR)) u_srf_device (.mclk(mclk),
    .sys_rst(sys_rst), .bus(bus_if), .dll_en_cfg(dll_en_cfg), .in_self_ref(in_self_ref),
    .refreshing(refreshing), .row_addr(row_addr), .dll_on(dll_on),
    .dll_reset(dll_reset), .ref_balance(ref_balance));
  srf_properties prop_chk (.mclk(mclk), .sys_rst(sys_rst), .cke(bus_if.cke),
    .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
    .odt(bus_if.odt), .reset_n(bus_if.reset_n), .addr(bus_if.addr));

  // Free-running clock; the link has no second domain.
  initial mclk = 1'b0;
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic chkb(input logic signed [4:0] got, input logic signed [4:0] exp,
                      input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Steps at falling edges so inputs never race the sampling edge.
  task automatic run(input int cyc);
    logic [ROW_W-1:0] r;
    repeat (cyc) begin
      r = row_addr;
      @(negedge mclk);
      if (dll_reset === 1'b1) pulse_seen = 1'b1;
      if (refreshing === 1'b1) ref_seen = 1'b1;
      if (row_addr !== r) rows_moved++;
    end
  endtask

  // Bounded wait; a refresh in flight may delay entry by a few cycles.
  task automatic wait_sr(input logic v);
    int n;
    n = 0;
    while (in_self_ref !== v && n < 400) begin
      run(1);
      n++;
    end
  endtask

  task automatic sr_cycle(input logic dll_sel);
    logic signed [4:0] bal;
    @(negedge mclk);
    dll_en_cfg = dll_sel;
    vref_off = ~dll_sel;
    sr_req = 1'b1;
    wait_sr(1'b1);
    chk1(in_self_ref, 1'b1, "self-refresh not entered");
    chk1(sr_active, 1'b1, "controller not in self-refresh");
    chk1(clk_stop_ok, 1'b0, "clock stop allowed too early");
    chk1(dll_on, 1'b0, "dll running in self-refresh");
    bal = ref_balance;
    rows_moved = 0;
    run(3 * TMR);
    chk1(rows_moved >= 2, 1'b1, "internal refresh timer idle");
    chk1(clk_stop_ok, 1'b1, "clock stop never allowed");
    chk1(in_self_ref, 1'b1, "left self-refresh with enable low");
    chkb(ref_balance, bal, "balance moved in self-refresh");
    pulse_seen = 1'b0;
    sr_req = 1'b0;
    wait_sr(1'b0);
    run(20);
    chk1(pulse_seen, ~dll_sel, "dll reset on exit");
    chk1(dll_cmd_ok, 1'b0, "dll commands too early");
    run(470);
    chk1(write_ok, dll_sel, "write gate early after exit");
    run(60);
    chk1(write_ok, 1'b1, "write never allowed");
    chk1(dll_cmd_ok, 1'b1, "dll commands never allowed");
    chk1(dll_on, ~dll_sel, "dll state after exit");
    $display("test self-refresh done");
  endtask

  // Cuts a hang short well beyond the expected run of some 1500 cycles.
  initial begin
    repeat (8000) @(posedge mclk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    sr_req = 1'b0;
    vref_off = 1'b1;
    dll_en_cfg = 1'b0;
    pulse_seen = 1'b0;
    ref_seen = 1'b0;
    rows_moved = 0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    run(3 * AVG_REFRESH_INTERVAL_CYC);
    chk1(ref_seen, 1'b1, "no refresh in three intervals");
    chk1(rows_moved > 0, 1'b1, "row counter idle");
    chk1(ref_balance <= 8 && ref_balance >= -8, 1'b1, "balance out of budget");
    chk1(sr_active, 1'b0, "self-refresh without request");
    $display("test normal refresh done");
    sr_cycle(1'b0);
    sr_cycle(1'b1);
    summarize();
  end
endmodule // srf_tb
